/* include/tsk_pkg.sv */
// Package: opcodes, timer field layout, reset values and carriers for the timer/skip op block
// Contract
// (RQ1) With the timer4 interrupt enable bit clear, the timer4 skip op skips the next op if the timer4 request flag is set, then clears it.
// (RQ2) With the timer4 interrupt enable bit set, the timer4 skip op does nothing at all.
// (RQ3) The serial start op clears the serial done flag and starts a serial transfer.
// (RQ4) The memory bit skip op skips the next op when bit j (0 to 3) of the nibble at the pointer is 0.
// (RQ5) Loading timer 1 writes B into the upper and A into the lower nibble of timer 1 and its reload latch.
// (RQ6) Loading timer 2 writes B into the upper and A into the lower nibble of timer 2 and its reload latch.
// (RQ7) Loading timer 3 writes B into the upper and A into the lower nibble of timer 3 and its reload latch.
// (RQ8) Loading timer 4 writes B into the upper and A into the lower nibble of timer 4 and its low reload latch.
// (RQ9) The high reload load op writes B into bits 7..4 and A into bits 3..0 of the timer4 high reload latch.
// (RQ10) The reload-to-timer4 op copies the whole low reload latch into the timer 4 count.
// (RQ11) The register move op copies B into A and leaves carry unchanged.
// (RQ12) Reading timer 1, 2 or 3 puts its upper count nibble in B and lower count nibble in A.
// (RQ13) A skipped op is fetched but has no effect on any register, flag or memory.
package tsk_pkg;
  localparam int unsigned TSK_NTIMER = 4;
  localparam int unsigned TSK_TW = 8;
  localparam int unsigned TSK_NW = 4;
  localparam int unsigned TSK_T4_IE_BIT = 1;
  localparam int unsigned TSK_HI_LSB = 4;
  localparam int unsigned TSK_LO_LSB = 0;
  localparam logic [7:0] TSK_TIMER_RST = 8'h00;
  localparam logic [3:0] TSK_NIB_RST = 4'h0;
  localparam logic [3:0] TSK_CTRL_RST = 4'h0;
  // APB map
  localparam logic [7:0] TSK_A_OP = 8'h00;
  localparam logic [7:0] TSK_A_AB = 8'h04;
  localparam logic [7:0] TSK_A_CTRL = 8'h08;
  localparam logic [7:0] TSK_A_TIMER = 8'h0c;
  localparam logic [7:0] TSK_A_RELOAD = 8'h10;
  localparam logic [7:0] TSK_A_STAT = 8'h14;
  localparam logic [7:0] TSK_A_IRQ_STAT = 8'h18;
  localparam logic [7:0] TSK_A_IRQ_CLR = 8'h1c;
  localparam logic [7:0] TSK_A_IRQ_EN = 8'h20;
  localparam logic [7:0] TSK_A_MEM = 8'h24;
  localparam int unsigned TSK_NIRQ = 4;
  localparam int unsigned TSK_IRQ_SKIP = 0;
  localparam int unsigned TSK_IRQ_SER = 1;
  localparam int unsigned TSK_IRQ_T4 = 2;
  localparam int unsigned TSK_IRQ_BADOP = 3;

  typedef enum logic [3:0] {
    TSK_OP_NOP = 4'h0,
    TSK_OP_SKIP_T4 = 4'h1,
    TSK_OP_SER_START = 4'h2,
    TSK_OP_SKIP_BIT = 4'h3,
    TSK_OP_LOAD_T1 = 4'h4,
    TSK_OP_LOAD_T2 = 4'h5,
    TSK_OP_LOAD_T3 = 4'h6,
    TSK_OP_LOAD_T4 = 4'h7,
    TSK_OP_LOAD_T4H = 4'h8,
    TSK_OP_RELOAD_T4 = 4'h9,
    TSK_OP_MOVE_BA = 4'ha,
    TSK_OP_READ_T1 = 4'hb,
    TSK_OP_READ_T2 = 4'hc,
    TSK_OP_READ_T3 = 4'hd,
    TSK_OP_SYS_RESET = 4'he
  } tsk_op_t;

  typedef struct packed {
    tsk_op_t op;
    logic [1:0] bit_sel;
  } tsk_cmd_t;

  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } tsk_byte_t;
endpackage : tsk_pkg

/* logic/tsk_apb_slave.sv */
// APB slave front end: one-wait-free handshake and the write and read strobes for the core
`timescale 1ns/1ps
module tsk_apb_slave
  import tsk_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  output logic pready_o,
  output logic wr_o,
  output logic rd_o
);
  // Ready only in the access phase of each transfer, so each one takes exactly two cycles
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= psel_i && !penable_i;
    end
  end

  always_comb begin
    wr_o = ce_i && psel_i && penable_i && pready_o && pwrite_i;
    rd_o = ce_i && psel_i && !penable_i && !pwrite_i;
  end
endmodule : tsk_apb_slave

/* logic/tsk_core.sv */
// Core: executes timer load/read, skip and serial-start ops with APB-visible state
`timescale 1ns/1ps
module tsk_core
  import tsk_pkg::*;
#(
  parameter int unsigned TW = TSK_TW
)(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic t4_event_i,
  input wire logic serial_done_i,
  output logic serial_start_o,
  output logic sys_reset_o,
  output logic irq_o
);
  logic wr;
  logic rd;
  logic [3:0] acc_q;
  logic [3:0] breg_q;
  logic carry_flag_q;
  logic [3:0] second_intr_control_reg_q;
  logic timer4_request_flag_q;
  logic serial_done_flag_q;
  logic skip_pending_q;
  logic [3:0] memory_at_pointer_q;
  logic [TW-1:0] timer_q [TSK_NTIMER];
  logic [TW-1:0] reload_q [TSK_NTIMER];
  logic [TW-1:0] fourth_high_reload_latch_q;
  logic [TSK_NIRQ-1:0] irq_stat_q;
  logic [TSK_NIRQ-1:0] irq_en_q;
  logic serial_start_q;
  logic sys_reset_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic t4_ev_s1_q;
  logic t4_ev_s2_q;
  logic sd_s1_q;
  logic sd_s2_q;
  tsk_cmd_t cmd;
  logic issue;
  logic exec;
  logic skip_t4_hit;
  logic skip_bit_hit;
  logic bad_op;
  logic addr_ok;

  tsk_apb_slave u_apb (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .pready_o(pready_o),
    .wr_o(wr),
    .rd_o(rd)
  );

  // Timer event and serial done come from other logic; treat as asynchronous
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      t4_ev_s1_q <= 1'b0;
      t4_ev_s2_q <= 1'b0;
      sd_s1_q <= 1'b0;
      sd_s2_q <= 1'b0;
    end else if (ce_i) begin
      t4_ev_s1_q <= t4_event_i;
      t4_ev_s2_q <= t4_ev_s1_q;
      sd_s1_q <= serial_done_i;
      sd_s2_q <= sd_s1_q;
    end
  end

  always_comb begin
    cmd = tsk_cmd_t'(pwdata_i[5:0]);
    issue = wr && (paddr_i == TSK_A_OP);
    exec = issue && !skip_pending_q; // RQ13
    skip_t4_hit = !second_intr_control_reg_q[TSK_T4_IE_BIT] && timer4_request_flag_q; // RQ1 RQ2
    skip_bit_hit = !memory_at_pointer_q[cmd.bit_sel]; // RQ4
    bad_op = !(cmd.op inside {TSK_OP_NOP, TSK_OP_SKIP_T4, TSK_OP_SER_START, TSK_OP_SKIP_BIT,
      TSK_OP_LOAD_T1, TSK_OP_LOAD_T2, TSK_OP_LOAD_T3, TSK_OP_LOAD_T4, TSK_OP_LOAD_T4H,
      TSK_OP_RELOAD_T4, TSK_OP_MOVE_BA, TSK_OP_READ_T1, TSK_OP_READ_T2, TSK_OP_READ_T3,
      TSK_OP_SYS_RESET});
    addr_ok = (paddr_i <= TSK_A_MEM) && (paddr_i[1:0] == 2'b00);
  end

  // A skip swallows exactly the next issued op, whatever it is
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      skip_pending_q <= 1'b0;
    end else if (ce_i && issue) begin
      if (skip_pending_q) begin
        skip_pending_q <= 1'b0; // RQ13
      end else if (cmd.op == TSK_OP_SKIP_T4) begin
        skip_pending_q <= skip_t4_hit; // RQ1 RQ2
      end else if (cmd.op == TSK_OP_SKIP_BIT) begin
        skip_pending_q <= skip_bit_hit; // RQ4
      end else begin
        skip_pending_q <= 1'b0;
      end
    end
  end

  // Accumulator, B and carry
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      acc_q <= TSK_NIB_RST;
      breg_q <= TSK_NIB_RST;
      carry_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (wr && paddr_i == TSK_A_AB) begin
        acc_q <= pwdata_i[3:0];
        breg_q <= pwdata_i[7:4];
        carry_flag_q <= pwdata_i[8];
      end else if (exec) begin
        case (cmd.op)
          TSK_OP_MOVE_BA: begin
            acc_q <= breg_q; // RQ11
          end
          TSK_OP_READ_T1: begin
            breg_q <= timer_q[0][TSK_HI_LSB +: TSK_NW]; // RQ12
            acc_q <= timer_q[0][TSK_LO_LSB +: TSK_NW];
          end
          TSK_OP_READ_T2: begin
            breg_q <= timer_q[1][TSK_HI_LSB +: TSK_NW]; // RQ12
            acc_q <= timer_q[1][TSK_LO_LSB +: TSK_NW];
          end
          TSK_OP_READ_T3: begin
            breg_q <= timer_q[2][TSK_HI_LSB +: TSK_NW]; // RQ12
            acc_q <= timer_q[2][TSK_LO_LSB +: TSK_NW];
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      second_intr_control_reg_q <= TSK_CTRL_RST;
      memory_at_pointer_q <= TSK_NIB_RST;
    end else if (ce_i && wr) begin
      if (paddr_i == TSK_A_CTRL) begin
        second_intr_control_reg_q <= pwdata_i[3:0];
      end else if (paddr_i == TSK_A_MEM) begin
        memory_at_pointer_q <= pwdata_i[3:0];
      end
    end
  end

  // Timers and reload latches; load ops write count and latch together
  genvar gi;
  generate
    for (gi = 0; gi < TSK_NTIMER; gi++) begin : g_tmr
      always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
          timer_q[gi] <= TW'(TSK_TIMER_RST);
          reload_q[gi] <= TW'(TSK_TIMER_RST);
        end else if (ce_i) begin
          if (exec && cmd.op == tsk_op_t'(4'(TSK_OP_LOAD_T1) + 4'(gi))) begin
            timer_q[gi] <= TW'({breg_q, acc_q}); // RQ5 RQ6 RQ7 RQ8
            reload_q[gi] <= TW'({breg_q, acc_q}); // RQ5 RQ6 RQ7 RQ8
          end else if (gi == TSK_NTIMER - 1 && exec && cmd.op == TSK_OP_RELOAD_T4) begin
            timer_q[gi] <= reload_q[gi]; // RQ10
          end else if (wr && paddr_i == TSK_A_TIMER && pwdata_i[9:8] == 2'(gi)) begin
            timer_q[gi] <= TW'(pwdata_i[7:0]);
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      fourth_high_reload_latch_q <= TW'(TSK_TIMER_RST);
    end else if (ce_i && exec && cmd.op == TSK_OP_LOAD_T4H) begin
      fourth_high_reload_latch_q <= TW'({breg_q, acc_q}); // RQ9
    end
  end

  // Request and done flags: a new event beats a clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      timer4_request_flag_q <= 1'b0;
      serial_done_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (t4_ev_s2_q) begin
        timer4_request_flag_q <= 1'b1;
      end else if (exec && cmd.op == TSK_OP_SKIP_T4 && skip_t4_hit) begin
        timer4_request_flag_q <= 1'b0; // RQ1
      end
      if (sd_s2_q) begin
        serial_done_flag_q <= 1'b1;
      end else if (exec && cmd.op == TSK_OP_SER_START) begin
        serial_done_flag_q <= 1'b0; // RQ3
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      serial_start_q <= 1'b0;
      sys_reset_q <= 1'b0;
    end else if (ce_i) begin
      serial_start_q <= exec && cmd.op == TSK_OP_SER_START; // RQ3
      sys_reset_q <= exec && cmd.op == TSK_OP_SYS_RESET;
    end
  end

  // Interrupt status: sticky, write-one-to-clear, set wins
  logic [TSK_NIRQ-1:0] irq_set;
  always_comb begin
    irq_set = '0;
    irq_set[TSK_IRQ_SKIP] = exec && ((cmd.op == TSK_OP_SKIP_T4 && skip_t4_hit)
      || (cmd.op == TSK_OP_SKIP_BIT && skip_bit_hit));
    irq_set[TSK_IRQ_SER] = sd_s2_q;
    irq_set[TSK_IRQ_T4] = t4_ev_s2_q;
    irq_set[TSK_IRQ_BADOP] = exec && bad_op; // RQ13
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (wr && paddr_i == TSK_A_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~pwdata_i[TSK_NIRQ-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (wr && paddr_i == TSK_A_IRQ_EN) begin
        irq_en_q <= pwdata_i[TSK_NIRQ-1:0];
      end
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  // Read data registered at setup; unmapped addresses answer with an error
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce_i && psel_i && !penable_i) begin
      pslverr_q <= !addr_ok;
      if (rd) begin
        if (paddr_i == TSK_A_AB) begin
          prdata_q <= {23'h0, carry_flag_q, breg_q, acc_q};
        end else if (paddr_i == TSK_A_CTRL) begin
          prdata_q <= {28'h0, second_intr_control_reg_q};
        end else if (paddr_i == TSK_A_TIMER) begin
          prdata_q <= {timer_q[3], timer_q[2], timer_q[1], timer_q[0]};
        end else if (paddr_i == TSK_A_RELOAD) begin
          prdata_q <= {fourth_high_reload_latch_q, reload_q[3], reload_q[1], reload_q[0]};
        end else if (paddr_i == TSK_A_STAT) begin
          prdata_q <= {reload_q[2], 21'h0, skip_pending_q, serial_done_flag_q,
            timer4_request_flag_q};
        end else if (paddr_i == TSK_A_IRQ_STAT) begin
          prdata_q <= {28'h0, irq_stat_q};
        end else if (paddr_i == TSK_A_IRQ_EN) begin
          prdata_q <= {28'h0, irq_en_q};
        end else if (paddr_i == TSK_A_MEM) begin
          prdata_q <= {28'h0, memory_at_pointer_q};
        end else begin
          prdata_q <= 32'h0000_0000;
        end
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  always_comb begin
    prdata_o = prdata_q;
    pslverr_o = pslverr_q;
    serial_start_o = serial_start_q;
    sys_reset_o = sys_reset_q;
  end
endmodule : tsk_core

/* sim/tsk_core_checker.sv */
// Port checker for the timer/skip op core
`timescale 1ns/1ps
module tsk_core_checker
  import tsk_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic t4_event_i,
  input wire logic serial_done_i,
  input wire logic serial_start_o,
  input wire logic sys_reset_o,
  input wire logic irq_o
);
  logic acc;
  logic bad_a;
  logic ser_w;
  logic rst_w;
  assign acc = psel_i && penable_i && pready_o;
  assign bad_a = (paddr_i > 8'h24) || (paddr_i[1:0] != 2'h0);
  assign ser_w = acc && pwrite_i && paddr_i == TSK_A_OP && pwdata_i[5:2] == TSK_OP_SER_START;
  assign rst_w = acc && pwrite_i && paddr_i == TSK_A_OP && pwdata_i[5:2] == TSK_OP_SYS_RESET;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  a_ready_access: assert property (psel_i && !penable_i && ce_i ##1 psel_i && penable_i && ce_i
    |-> pready_o) else $error("pready missing in access phase");
  a_ready_idle: assert property (!psel_i |-> !pready_o) else $error("pready without select");
  a_ready_single: assert property (pready_o |=> !pready_o) else $error("pready held too long");
  a_err_unmapped: assert property (acc && bad_a |-> pslverr_o) else $error("no slave error");
  a_err_mapped: assert property (acc && !bad_a |-> !pslverr_o) else $error("spurious slave error");
  a_unmapped_zero: assert property (acc && bad_a && !pwrite_i |-> prdata_o == 32'h0)
    else $error("unmapped read data not zero");
  a_serial_cause: assert property (serial_start_o |-> $past(ser_w) || $past(ser_w, 2))
    else $error("serial start without its op");
  a_sysrst_cause: assert property (sys_reset_o |-> $past(rst_w) || $past(rst_w, 2))
    else $error("system reset without its op");
  c_serial: cover property (ser_w);
  c_irq: cover property (irq_o);
  c_refused: cover property (acc && bad_a);
endmodule : tsk_core_checker

bind tsk_core tsk_core_checker u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .t4_event_i(t4_event_i), .serial_done_i(serial_done_i), .serial_start_o(serial_start_o),
  .sys_reset_o(sys_reset_o), .irq_o(irq_o));

/* sim/tsk_core_tb_top.sv */
// Self-checking bench for the timer/skip op core
`timescale 1ns/1ps
module tsk_core_tb_top
  import tsk_pkg::*;
;
  logic clock_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic t4_ev = 1'b0, ser_done = 1'b0, pready, pslverr, ser_start, sys_rst, irq, last_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int n_mismatch = 0, checks_done = 0, n_ser = 0, n_sys = 0;

  initial begin
    forever #2 clock_i = ~clock_i;
  end

  tsk_core DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .t4_event_i(t4_ev),
    .serial_done_i(ser_done), .serial_start_o(ser_start), .sys_reset_o(sys_rst), .irq_o(irq));

  // Pulses are one cycle wide, so each is seen at exactly one edge
  always @(posedge clock_i) begin
    if (ser_start === 1'b1) n_ser <= n_ser + 1;
    if (sys_rst === 1'b1) n_sys <= n_sys + 1;
  end

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic op(input logic [3:0] o, input logic [1:0] j);
    wr(TSK_A_OP, {26'h0, o, j});
  endtask : op

  // Events are held for two cycles so the two-stage synchroniser cannot miss them
  task automatic bump(input logic t4);
    @(posedge clock_i);
    t4_ev <= t4;
    ser_done <= !t4;
    repeat (2) @(posedge clock_i);
    t4_ev <= 1'b0;
    ser_done <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask : bump

  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(TSK_A_AB, {24'h0, 4'h1 + 4'(i), 4'hc - 4'(i)});
      op(4'(TSK_OP_LOAD_T1 + i), 2'h0);
    end
    rdc(TSK_A_TIMER, 32'h493a2b1c);
    rdc(TSK_A_RELOAD, 32'h00492b1c);
    rdc(TSK_A_STAT, 32'h3a000000);
    wr(TSK_A_AB, 32'h0d6);
    op(TSK_OP_LOAD_T4H, 2'h0);
    rdc(TSK_A_RELOAD, 32'hd6492b1c);
    wr(TSK_A_TIMER, 32'h377);
    op(TSK_OP_RELOAD_T4, 2'h0);
    rdc(TSK_A_TIMER, 32'h493a2b1c);
    wr(TSK_A_AB, 32'h100);
    for (int i = 0; i < 3; i++) begin
      op(4'(TSK_OP_READ_T1 + i), 2'h0);
      rdc(TSK_A_AB, {23'h0, 1'b1, 4'h1 + 4'(i), 4'hc - 4'(i)});
    end
    wr(TSK_A_AB, 32'h157);
    op(TSK_OP_MOVE_BA, 2'h0);
    rdc(TSK_A_AB, 32'h155);
    wr(TSK_A_MEM, 32'h5);
    for (int j = 0; j < 4; j++) begin
      wr(TSK_A_AB, 32'h90 + j);
      op(TSK_OP_SKIP_BIT, 2'(j));
      op(TSK_OP_MOVE_BA, 2'h0);
      rdc(TSK_A_AB, (j % 2 == 0) ? 32'h99 : 32'h90 + j);
    end
    for (int k = 0; k < 2; k++) begin
      wr(TSK_A_CTRL, 32'(2 * k));
      bump(1'b1);
      wr(TSK_A_AB, 32'h0a3);
      op(TSK_OP_SKIP_T4, 2'h0);
      op(TSK_OP_MOVE_BA, 2'h0);
      rdc(TSK_A_AB, (k != 0) ? 32'h0aa : 32'h0a3);
      rdc(TSK_A_STAT, 32'h3a000000 | k);
    end
    bump(1'b0);
    rdc(TSK_A_STAT, 32'h3a000003);
    op(TSK_OP_SER_START, 2'h0);
    repeat (3) @(posedge clock_i);
    chk(n_ser, 32'h1);
    rdc(TSK_A_STAT, 32'h3a000001);
    rdc(TSK_A_IRQ_STAT, 32'h7);
    wr(TSK_A_IRQ_EN, 32'h8);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    wr(TSK_A_IRQ_EN, 32'h2);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq}, 32'h1);
    wr(TSK_A_IRQ_CLR, 32'h2);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    rdc(TSK_A_IRQ_STAT, 32'h5);
    rdc(TSK_A_IRQ_EN, 32'h2);
    op(TSK_OP_SKIP_BIT, 2'h1);
    rdc(TSK_A_STAT, 32'h3a000005);
    op(4'hf, 2'h0);
    rdc(TSK_A_IRQ_STAT, 32'h5);
    op(4'hf, 2'h0);
    rdc(TSK_A_IRQ_STAT, 32'hd);
    rdc(8'h28, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    op(TSK_OP_SYS_RESET, 2'h0);
    repeat (3) @(posedge clock_i);
    chk(n_sys, 32'h1);
    give_verdict();
  end
endmodule : tsk_core_tb_top
